// ---- logic/t3c_timer.sv ----
`timescale 1ns/1ps
module t3c_timer
  import t3c_pkg::*;
#(
  parameter int SYS_DIV = t3c_pkg::SYS_DIVIDE,
  parameter int EXT_DIV = t3c_pkg::EXT_DIVIDE
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Clock sources and clock-control choices
  input wire logic ext_clk,
  input wire logic lfo_clk,
  input wire logic high_byte_clock_choice,
  input wire logic low_byte_clock_choice,
  // Interrupt
  input wire logic timer_irq_enable,
  output logic timer_irq
);
  import t3c_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (SYS_DIV < 2 || SYS_DIV > 15) begin : g_bad_sys
    $error("SYS_DIV must lie in 2..15");
  end
  if (EXT_DIV < 2 || EXT_DIV > 15) begin : g_bad_ext
    $error("EXT_DIV must lie in 2..15");
  end
  localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] EXT_LAST = 4'(EXT_DIV - 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic high_overflow_flag_r;
  logic low_overflow_flag_r;
  logic low_overflow_irq_enable_r;
  logic capture_enable_r;
  logic split_select_r;
  logic run_control_r;
  logic external_clock_select_r;
  logic [7:0] reload_low_r;
  logic [7:0] reload_high_r;
  logic [3:0] sys_div_r;
  logic [3:0] ext_div_r;
  logic ext_q_r;
  logic lfo_q_r;
  logic [7:0] rdata_r;
  logic irq_r;

  t3c_byte_if lo_if ();
  t3c_byte_if hi_if ();

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONTROL);
  wire wr_rll = sfr_wr && (sfr_addr == ADDR_RELOAD_LOW);
  wire wr_rlh = sfr_wr && (sfr_addr == ADDR_RELOAD_HIGH);
  wire wr_cl = sfr_wr && (sfr_addr == ADDR_COUNT_LOW);
  wire wr_ch = sfr_wr && (sfr_addr == ADDR_COUNT_HIGH);

  // ----------------------------------------
  // Count sources
  // ----------------------------------------
  // The external clock is sampled as a plain synchronous input; its rising
  // edges are counted, so it must stay below half the system clock rate.
  wire ext_rise = ext_clk && !ext_q_r;
  wire sys_tick = (sys_div_r == SYS_LAST);
  wire ext_tick = ext_rise && (ext_div_r == EXT_LAST);
  wire base_tick = external_clock_select_r ? ext_tick : sys_tick;
  wire tick_lo = low_byte_clock_choice ? 1'b1 : base_tick;
  wire tick_hi = high_byte_clock_choice ? 1'b1 : base_tick;
  wire cap_evt = capture_enable_r && lfo_q_r && !lfo_clk;

  // ----------------------------------------
  // Counter steering
  // ----------------------------------------
  wire full_wrap = !split_select_r && hi_if.wrap;
  wire lo_reload = !capture_enable_r && (split_select_r ? lo_if.wrap : full_wrap);
  wire hi_reload = !capture_enable_r && hi_if.wrap;
  assign lo_if.inc = split_select_r ? tick_lo : (run_control_r && tick_lo);
  assign hi_if.inc = split_select_r ? (run_control_r && tick_hi) : lo_if.wrap;
  assign lo_if.load = wr_cl || lo_reload;
  assign hi_if.load = wr_ch || hi_reload;
  assign lo_if.ld_val = wr_cl ? sfr_wdata : reload_low_r;
  assign hi_if.ld_val = wr_ch ? sfr_wdata : reload_high_r;

  t3c_byte_cnt u_lo (.mclk(mclk), .reset(reset), .ce(ce), .bi(lo_if.cnt_side));
  t3c_byte_cnt u_hi (.mclk(mclk), .reset(reset), .ce(ce), .bi(hi_if.cnt_side));

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  // A hardware set wins over a software clear in the same cycle.
  wire hf_set = hi_if.wrap || cap_evt;
  wire hf_nxt = hf_set || (wr_ctrl ? sfr_wdata[BIT_HIGH_FLAG] : high_overflow_flag_r);
  wire lf_nxt = lo_if.wrap || (wr_ctrl ? sfr_wdata[BIT_LOW_FLAG] : low_overflow_flag_r);
  wire irq_nxt = timer_irq_enable && (high_overflow_flag_r ||
                 (low_overflow_irq_enable_r && low_overflow_flag_r));

  wire [7:0] ctrl_view = {high_overflow_flag_r, low_overflow_flag_r, low_overflow_irq_enable_r,
                          capture_enable_r, split_select_r, run_control_r, 1'b0,
                          external_clock_select_r};
  wire [7:0] rd_mux = (sfr_addr == ADDR_CONTROL) ? ctrl_view :
                      (sfr_addr == ADDR_RELOAD_LOW) ? reload_low_r :
                      (sfr_addr == ADDR_RELOAD_HIGH) ? reload_high_r :
                      (sfr_addr == ADDR_COUNT_LOW) ? lo_if.cnt :
                      (sfr_addr == ADDR_COUNT_HIGH) ? hi_if.cnt : RESET_BYTE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_div_r <= DIV_ZERO;
      ext_div_r <= DIV_ZERO;
      ext_q_r <= 1'b0;
      lfo_q_r <= 1'b0;
    end else if (ce) begin
      sys_div_r <= sys_tick ? DIV_ZERO : 4'(sys_div_r + DIV_ONE);
      ext_q_r <= ext_clk;
      lfo_q_r <= lfo_clk;
      if (ext_rise) begin
        ext_div_r <= ext_tick ? DIV_ZERO : 4'(ext_div_r + DIV_ONE);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r <= 1'b0;
      {low_overflow_irq_enable_r, capture_enable_r, split_select_r} <= 3'h0;
      {run_control_r, external_clock_select_r} <= 2'h0;
    end else if (ce) begin
      high_overflow_flag_r <= hf_nxt;
      low_overflow_flag_r <= lf_nxt;
      if (wr_ctrl) begin
        low_overflow_irq_enable_r <= sfr_wdata[BIT_LOW_IRQ_EN];
        capture_enable_r <= sfr_wdata[BIT_CAPTURE_EN];
        split_select_r <= sfr_wdata[BIT_SPLIT];
        run_control_r <= sfr_wdata[BIT_RUN];
        external_clock_select_r <= sfr_wdata[BIT_EXT_CLK];
      end
    end
  end

  // Capture takes priority over a software write landing in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      reload_low_r <= RESET_BYTE;
      reload_high_r <= RESET_BYTE;
    end else if (ce) begin
      if (cap_evt) begin
        reload_low_r <= lo_if.cnt;
        reload_high_r <= hi_if.cnt;
      end else begin
        if (wr_rll) begin
          reload_low_r <= sfr_wdata;
        end
        if (wr_rlh) begin
          reload_high_r <= sfr_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= RESET_BYTE;
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_nxt;
      if (sfr_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign sfr_rdata = rdata_r;
  assign timer_irq = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_high_set;
    @(posedge mclk) disable iff (reset) (ce && hi_if.wrap) |=> high_overflow_flag_r;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag not set on high wrap");

  property p_full_wrap;
    @(posedge mclk) disable iff (reset)
      (ce && !split_select_r && hi_if.inc) |-> (lo_if.cnt == BYTE_MAX);
  endproperty
  a_full_wrap: assert property (p_full_wrap) else $error("high byte moved without low wrap");

  property p_irq_high;
    @(posedge mclk) disable iff (reset)
      (ce && timer_irq_enable && high_overflow_flag_r) |=> timer_irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("interrupt missing for high flag");

  property p_flag_sticky;
    @(posedge mclk) disable iff (reset)
      (high_overflow_flag_r && !(ce && wr_ctrl)) |=> high_overflow_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("high flag cleared by hardware");

  property p_low_set;
    @(posedge mclk) disable iff (reset) (ce && lo_if.wrap) |=> low_overflow_flag_r;
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag not set on low wrap");

  property p_irq_mask;
    @(posedge mclk) disable iff (reset) (ce && !timer_irq_enable) |=> !timer_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");

  property p_capture;
    @(posedge mclk) disable iff (reset)
      (ce && cap_evt) |=> (reload_low_r == $past(lo_if.cnt)) && (reload_high_r == $past(hi_if.cnt));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_run_halt;
    @(posedge mclk) disable iff (reset)
      (ce && !split_select_r && !run_control_r && !wr_cl && !wr_ch) |=> $stable(lo_if.cnt);
  endproperty
  a_run_halt: assert property (p_run_halt) else $error("count moved while halted");

  property p_reload16;
    @(posedge mclk) disable iff (reset)
      (ce && full_wrap && !capture_enable_r && !wr_cl && !wr_ch)
      |=> ({hi_if.cnt, lo_if.cnt} == {$past(reload_high_r), $past(reload_low_r)});
  endproperty
  a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

  property p_irq_low;
    @(posedge mclk) disable iff (reset)
      (ce && timer_irq_enable && low_overflow_irq_enable_r && low_overflow_flag_r) |=> timer_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt missing for low flag");

  property p_irq_low_off;
    @(posedge mclk) disable iff (reset)
      (ce && !high_overflow_flag_r && !low_overflow_irq_enable_r) |=> !timer_irq;
  endproperty
  a_irq_low_off: assert property (p_irq_low_off) else $error("low flag raised a disabled interrupt");

  property p_capture_flag;
    @(posedge mclk) disable iff (reset) (ce && cap_evt) |=> high_overflow_flag_r;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture did not raise the flag");

  property p_low_sticky;
    @(posedge mclk) disable iff (reset)
      (low_overflow_flag_r && !(ce && wr_ctrl)) |=> low_overflow_flag_r;
  endproperty
  a_low_sticky: assert property (p_low_sticky) else $error("low flag cleared by hardware");

  property p_split_low_runs;
    @(posedge mclk) disable iff (reset)
      (ce && split_select_r && tick_lo && !lo_if.wrap && !wr_cl)
      |=> (lo_if.cnt == 8'($past(lo_if.cnt) + 8'h01));
  endproperty
  a_split_low_runs: assert property (p_split_low_runs) else $error("split low byte did not count");

  property p_split_high_halt;
    @(posedge mclk) disable iff (reset)
      (ce && split_select_r && !run_control_r && !wr_ch) |=> $stable(hi_if.cnt);
  endproperty
  a_split_high_halt: assert property (p_split_high_halt) else $error("split high byte moved while halted");

  property p_low_reload;
    @(posedge mclk) disable iff (reset)
      (ce && !capture_enable_r && split_select_r && lo_if.wrap && !wr_cl) |=> (lo_if.cnt == $past(reload_low_r));
  endproperty
  a_low_reload: assert property (p_low_reload) else $error("split low reload wrong");

  property p_high_reload;
    @(posedge mclk) disable iff (reset)
      (ce && !capture_enable_r && hi_if.wrap && !wr_ch) |=> (hi_if.cnt == $past(reload_high_r));
  endproperty
  a_high_reload: assert property (p_high_reload) else $error("high reload wrong");

  property p_capture_hold;
    @(posedge mclk) disable iff (reset)
      (ce && capture_enable_r && !cap_evt && !wr_rll) |=> $stable(reload_low_r);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("captured low byte changed");

  property p_sys_divide;
    @(posedge mclk) disable iff (reset) (ce && sys_tick) |=> (sys_div_r == DIV_ZERO);
  endproperty
  a_sys_divide: assert property (p_sys_divide) else $error("system divider did not restart");

  c_split_low: cover property (@(posedge mclk) disable iff (reset) ce && split_select_r && lo_if.wrap);
  c_full_wrap: cover property (@(posedge mclk) disable iff (reset) ce && full_wrap);
  c_capture: cover property (@(posedge mclk) disable iff (reset) ce && cap_evt && timer_irq_enable);
  c_ext_tick: cover property (@(posedge mclk) disable iff (reset) ce && external_clock_select_r && ext_tick);
endmodule

// ---- logic/t3c_pkg.sv ----
// What this block does
// - Set the high overflow flag when the high byte rolls from 0xFF to 0x00.
// - In 16-bit mode the high flag rises only on the 0xFFFF to 0x0000 wrap or on a capture.
// - With the timer interrupt enabled, a set high flag requests the interrupt.
// - Hardware never clears either overflow flag; software clears it by writing.
// - Set the low overflow flag at every low byte wrap, in every mode.
// - Low overflow requests an interrupt when its enable and the timer interrupt are set.
// - With capture enabled, copy the 16-bit count to the reload bytes on oscillator falls.
// - With capture and the timer interrupt enabled, each capture requests an interrupt.
// - Split select 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - In 16-bit mode counting happens only while run control is 1.
// - In split mode run control gates only the high byte; the low byte always counts.
// - Clock select: 0 is system clock over 12, 1 is external clock over 8.
// - In split mode the clock select applies to both bytes; per-byte choices may override.
// - In auto-reload modes the reload low byte feeds the low byte on reload.
// - In capture mode the reload low byte holds the captured low count.
// - The reload high byte is the high reload value, or the captured high count.
// - The count bytes are read-write; one 16-bit count or two 8-bit counts.
package t3c_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_EXT_CLK = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  localparam logic [3:0] DIV_ONE = 4'h1;
endpackage

// ---- logic/t3c_byte_if.sv ----
`timescale 1ns/1ps
interface t3c_byte_if;
  logic inc;
  logic load;
  logic [7:0] ld_val;
  logic [7:0] cnt;
  logic wrap;
  modport ctl (output inc, output load, output ld_val, input cnt, input wrap);
  modport cnt_side (input inc, input load, input ld_val, output cnt, output wrap);
endinterface

// ---- logic/t3c_byte_cnt.sv ----
`timescale 1ns/1ps
module t3c_byte_cnt
  import t3c_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Counter port
  t3c_byte_if.cnt_side bi
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // A load wins over a count so a write or reload is never lost.
  assign cnt_nxt = bi.load ? bi.ld_val : (bi.inc ? 8'(cnt_r + 8'h01) : cnt_r);
  assign bi.cnt = cnt_r;
  assign bi.wrap = bi.inc && (cnt_r == BYTE_MAX);

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= RESET_BYTE;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ---- sim/t3c_timer_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module t3c_timer_test;
  import t3c_pkg::*;
  // ----------------------------------------
  // Stimulus and notes
  // ----------------------------------------
  typedef struct {string nm; logic [7:0] ex;} t3c_note_t;
  t3c_note_t notes[$];
  t3c_note_t nt;
  int failures = 0;
  int n_checks = 0;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic ext_clk = 1'b0;
  logic lfo_clk = 1'b0;
  logic hi_choice = 1'b0;
  logic lo_choice = 1'b1;
  logic irq_en = 1'b1;
  logic timer_irq;
  logic pend = 1'b0;
  logic [7:0] rv;
  always #2.5 mclk = ~mclk;
  t3c_timer dut_u (.mclk(mclk), .reset(reset), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_clk(ext_clk),
    .lfo_clk(lfo_clk), .high_byte_clock_choice(hi_choice), .low_byte_clock_choice(lo_choice),
    .timer_irq_enable(irq_en), .timer_irq(timer_irq));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // The note is queued before the strobe so the watcher always finds it.
  task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] ex);
    notes.push_back('{nm, ex});
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk);
      if (timer_irq === 1'b1) break;
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Read data watcher
  // ----------------------------------------
  initial begin
    forever begin
      @(posedge mclk);
      #1;
      if (pend) begin
        nt = notes.pop_front();
        `CHK(nt.nm, nt.ex, sfr_rdata)
      end
      pend = sfr_rd;
    end
  end
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(68));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int a = 8'h90; a <= 8'h96; a++) rd(a[7:0], "reset value", RESET_BYTE);
    wr(8'h90, 8'hA5);
    rd(8'h90, "unmapped", 8'h00);
    for (int a = 8'h92; a <= 8'h95; a++) begin
      rv = 8'($urandom);
      wr(a[7:0], rv);
      rd(a[7:0], "rw byte", rv);
    end
    wr(ADDR_CONTROL, 8'h02);
    rd(ADDR_CONTROL, "reserved bit", 8'h00);
    wr(ADDR_RELOAD_LOW, rv);
    ce <= 1'b0;
    wr(ADDR_RELOAD_LOW, 8'h3C);
    ce <= 1'b1;
    rd(ADDR_RELOAD_LOW, "frozen write", rv);
    // Low wrap alone in 16-bit mode must leave the high flag clear.
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    repeat (10) @(posedge mclk);
    rd(ADDR_CONTROL, "low wrap flags", 8'h44);
    // Level outputs are looked at mid-cycle, clear of the edge that launches them.
    @(negedge mclk);
    `CHK("irq masked low", 1'b0, timer_irq)
    @(posedge mclk);
    wr(ADDR_CONTROL, 8'h24);
    wait_irq(300);
    @(negedge mclk);
    `CHK("low irq", 1'b1, timer_irq)
    @(posedge mclk);
    wr(ADDR_CONTROL, 8'h04);
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hF0);
    wait_irq(100);
    @(negedge mclk);
    `CHK("high irq", 1'b1, timer_irq)
    @(posedge mclk);
    wr(ADDR_CONTROL, 8'hC0);
    repeat (20) @(posedge mclk);
    rd(ADDR_CONTROL, "sticky flags", 8'hC0);
    rd(ADDR_COUNT_HIGH, "reloaded high", 8'h12);
    irq_en <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("irq gated", 1'b0, timer_irq)
    @(posedge mclk);
    irq_en <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("irq ungated", 1'b1, timer_irq)
    @(posedge mclk);
    // Split mode with run off: only the low byte may move.
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h55);
    wr(ADDR_COUNT_LOW, 8'h00);
    hi_choice <= 1'b1;
    wr(ADDR_CONTROL, 8'h08);
    repeat (300) @(posedge mclk);
    rd(ADDR_CONTROL, "split flags", 8'h48);
    rd(ADDR_COUNT_HIGH, "split high held", 8'h55);
    // Capture on a falling edge of the oscillator.
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hCD);
    wr(ADDR_COUNT_HIGH, 8'hAB);
    wr(ADDR_CONTROL, 8'h10);
    lfo_clk <= 1'b1;
    repeat (3) @(posedge mclk);
    lfo_clk <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(ADDR_RELOAD_LOW, "capture low", 8'hCD);
    rd(ADDR_RELOAD_HIGH, "capture high", 8'hAB);
    rd(ADDR_CONTROL, "capture flag", 8'h90);
    @(negedge mclk);
    `CHK("capture irq", 1'b1, timer_irq)
    @(posedge mclk);
    // The divider runs free, so a run window of 144 cycles holds twelve ticks in any phase.
    wr(ADDR_CONTROL, 8'h00);
    lo_choice <= 1'b0;
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    repeat (142) @(posedge mclk);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, "divide by 12", 8'h0C);
    // External clock: sixteen sampled rising edges give two ticks.
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h05);
    repeat (16) begin
      ext_clk <= 1'b1;
      repeat (2) @(posedge mclk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, "divide by 8", 8'h02);
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule
